// ===== core/sram_ctl.sv
// Controller driving an asynchronous byte-wide static memory
// Overview of operation
// (R1) Write happens while select and strobe low; data latched at first rise.
// (R2) Memory drives data only with select, output enable low, strobe high.
// (R3) Each read cycle lasts at least 55 ns.
// (R4) Read data valid within 55 ns of select low or address.
// (R5) Read data valid within 25 ns of output enable low.
// (R6) Memory holds old read data at least 10 ns after address change.
// (R7) Memory drivers leave high impedance no sooner than 10 ns after select.
// (R8) Memory drivers float within 20 ns after select rises.
// (R9) Drivers float within 20 ns of enable rise; not active before 5 ns.
// (R10) Write cycle at least 55 ns, write strobe low at least 35 ns.
// (R11) Select low and address stable 40 ns before write end.
// (R12) Write data valid 25 ns before write end; hold 0 ns.
// (R13) Address setup, hold and recovery around writes are 0 ns.
// (R14) Memory floats its drivers within 20 ns after strobe falls.
// (R15) Memory re-enables drivers no sooner than 5 ns after write end.
// (R16) Select or strobe high whenever the address changes.
// (R17) Write ends when select or strobe returns high.
// (R18) Address valid no later than select falling in a read.
// (R19) Write strobe stays high throughout every read.
// (R20) Chip may be deselected on entering retention, gap 0.
// (R21) After retention, wait one read cycle before a new access.
// (R22) Memory is 524288 bytes, 19 address lines, 8-bit two-way port.
`timescale 1ns/1ps
module sram_ctl #(
   parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
   parameter int DATA_W = sram_ctl_pkg::DATA_W
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // User request side
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   input wire logic RETAIN,
   output logic REQ_READY,
   output logic RD_VALID,
   output logic [DATA_W-1:0] RD_DATA,
   // Memory pins
   output logic [ADDR_W-1:0] MEM_ADDR,
   output logic MEM_CS_N,
   output logic MEM_WE_N,
   output logic MEM_OE_N,
   input wire logic [DATA_W-1:0] DATA_PORT_I,
   output logic [DATA_W-1:0] DATA_PORT_O,
   output logic DATA_PORT_OE
);
   localparam int CW = 4;
   localparam logic [CW-1:0] RD_LAST = CW'(sram_ctl_pkg::READ_CYCLE_MIN + 3);
   localparam logic [CW-1:0] FLT_LAST = CW'(sram_ctl_pkg::FLOAT_WAIT);
   localparam logic [CW-1:0] WP_LAST = CW'(sram_ctl_pkg::WRITE_PULSE_MIN);
   localparam logic [CW-1:0] REC_LAST = CW'(sram_ctl_pkg::READ_CYCLE_MIN);

   sram_ctl_pkg::state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic cs_n_q, cs_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, doe_q, doe_d;
   logic ready_q, ready_d, rvalid_q, rvalid_d, retain_q;
   logic [DATA_W-1:0] din_sync;
   logic [0:0] retain_sync;

   // Read data comes from a pin, so it passes the three-stage filter
   sram_sync3 #(.W(DATA_W)) u_dsync (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .din(DATA_PORT_I),
      .dout(din_sync)
   );

   // Retention request may be asynchronous too
   sram_sync3 #(.W(1)) u_rsync (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .din(RETAIN),
      .dout(retain_sync)
   );

   // Sequencer: one access at a time, all strobes from flops
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + CW'(1);
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      cs_n_d = cs_n_q;
      we_n_d = we_n_q;
      oe_n_d = oe_n_q;
      doe_d = doe_q;
      ready_d = 1'b0;
      rvalid_d = 1'b0;
      case (state_q)
         sram_ctl_pkg::ST_IDLE: begin
            cnt_d = '0;
            cs_n_d = 1'b1;
            oe_n_d = 1'b1;
            we_n_d = 1'b1; // R19
            doe_d = 1'b0;
            if (retain_sync[0]) begin
               state_d = sram_ctl_pkg::ST_RECOVER; // R20
            end else if (REQ_VALID && ready_q) begin
               // Address set while select high, so no write sees it move
               addr_d = REQ_ADDR; // R16 R18 R13
               wdata_d = REQ_WDATA;
               if (REQ_WRITE) begin
                  cs_n_d = 1'b0;
                  state_d = sram_ctl_pkg::ST_WFLOAT;
               end else begin
                  cs_n_d = 1'b0; // R18
                  oe_n_d = 1'b0;
                  state_d = sram_ctl_pkg::ST_READ;
               end
            end else begin
               ready_d = 1'b1;
            end
         end
         sram_ctl_pkg::ST_READ: begin
            // Extra cycles cover the input filter latency
            if (cnt_q == RD_LAST) begin // R3 R4 R5
               rdata_d = din_sync;
               rvalid_d = 1'b1;
               cs_n_d = 1'b1;
               oe_n_d = 1'b1;
               cnt_d = '0;
               state_d = sram_ctl_pkg::ST_WEND;
            end
         end
         sram_ctl_pkg::ST_WFLOAT: begin
            // Strobe low right away; we drive only after the memory floats
            we_n_d = 1'b0;
            if (cnt_q == FLT_LAST) begin // R14 R2
               doe_d = 1'b1;
               cnt_d = '0;
               state_d = sram_ctl_pkg::ST_WRITE;
            end
         end
         sram_ctl_pkg::ST_WRITE: begin
            // Pulse counted from data drive gives data setup as well
            if (cnt_q == WP_LAST) begin // R10 R11 R12
               we_n_d = 1'b1; // R1 R17
               cs_n_d = 1'b1;
               cnt_d = '0;
               state_d = sram_ctl_pkg::ST_WEND;
            end
         end
         sram_ctl_pkg::ST_WEND: begin
            // Data held one cycle past the strobe rise, then released
            doe_d = 1'b0; // R12
            state_d = sram_ctl_pkg::ST_IDLE;
            ready_d = 1'b1;
         end
         sram_ctl_pkg::ST_RECOVER: begin
            cs_n_d = 1'b1; // R20
            if (retain_sync[0]) begin
               cnt_d = '0;
            end else if (cnt_q == REC_LAST) begin // R21
               state_d = sram_ctl_pkg::ST_IDLE;
               ready_d = 1'b1;
            end
         end
         default: begin
            state_d = sram_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= sram_ctl_pkg::ST_IDLE;
         cnt_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         cs_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         doe_q <= 1'b0;
         ready_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         cs_n_q <= cs_n_d;
         we_n_q <= we_n_d;
         oe_n_q <= oe_n_d;
         doe_q <= doe_d;
         ready_q <= ready_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign retain_q = retain_sync[0];
   assign MEM_ADDR = addr_q;
   assign MEM_CS_N = cs_n_q;
   assign MEM_WE_N = we_n_q;
   assign MEM_OE_N = oe_n_q;
   assign DATA_PORT_O = wdata_q;
   assign DATA_PORT_OE = doe_q;
   assign REQ_READY = ready_q;
   assign RD_VALID = rvalid_q;
   assign RD_DATA = rdata_q;

   // Checks on the driven pins
   chk_addr_stable: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      !$stable(MEM_ADDR) |-> $past(MEM_CS_N)) // R16
      else $error("address moved while selected");
   chk_read_strobe: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      !MEM_OE_N |-> MEM_WE_N) // R19
      else $error("write strobe low during read");
   chk_write_pulse: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      $fell(MEM_WE_N) |-> !MEM_WE_N [*8]) // R10
      else $error("write pulse too short");
   chk_select_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      !MEM_WE_N |-> !MEM_CS_N) // R11
      else $error("strobe low without select");
   chk_data_setup: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      $rose(MEM_WE_N) |-> $past(DATA_PORT_OE, 4)) // R12
      else $error("write data set up too late");
   chk_no_contend: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      DATA_PORT_OE |-> MEM_OE_N) // R2
      else $error("drive while memory may drive");
   chk_read_length: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      $fell(MEM_OE_N) |-> !MEM_OE_N [*8]) // R3
      else $error("read cycle too short");
   chk_write_end: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      $rose(MEM_WE_N) |-> MEM_CS_N && DATA_PORT_OE) // R17
      else $error("write end not clean");
   chk_retain_sel: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      state_q == sram_ctl_pkg::ST_RECOVER |-> MEM_CS_N) // R20
      else $error("selected in retention");
   chk_recover_wait: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      $fell(retain_q) && state_q == sram_ctl_pkg::ST_RECOVER
      |-> !REQ_READY [*7]) // R21
      else $error("access too soon after retention");
   cov_read: cover property (@(posedge REF_CLK) RD_VALID);
   cov_write: cover property (@(posedge REF_CLK) $rose(MEM_WE_N));
   cov_retain: cover property (@(posedge REF_CLK)
      state_q == sram_ctl_pkg::ST_RECOVER);
endmodule

// ===== core/sram_ctl_pkg.sv
// Shared constants for the asynchronous byte-wide memory controller
package sram_ctl_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   // Times in ns as printed
   localparam int READ_CYCLE_MIN_NS = 55;
   localparam int WRITE_CYCLE_MIN_NS = 55;
   localparam int WRITE_PULSE_MIN_NS = 35;
   localparam int SELECT_TO_END_NS = 40;
   localparam int DATA_SETUP_NS = 25;
   localparam int OE_TO_DATA_NS = 25;
   localparam int FLOAT_MAX_NS = 20;
   // Least times round up to whole cycles
   localparam int READ_CYCLE_MIN =
      (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLE_MIN =
      (WRITE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_MIN =
      (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_TO_END =
      (SELECT_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_SETUP =
      (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOAT_WAIT =
      (FLOAT_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // One-hot-free binary state codes
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_READ = 3'h1,
      ST_WFLOAT = 3'h2,
      ST_WRITE = 3'h3,
      ST_WEND = 3'h4,
      ST_RECOVER = 3'h5
   } state_t;
endpackage

// ===== core/sram_sync3.sv
// Three-stage input filter; a change counts once stages two and three agree
`timescale 1ns/1ps
module sram_sync3 #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   // Accept a bit only once two later stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule

// ===== bench/sram_model.sv
// Behavioural model of the byte-wide static memory on the far side
`timescale 1ns/1ps
module sram_model (
   // Memory pins
   input wire logic [18:0] addr,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [7:0] din,
   // Data port drive
   output logic [7:0] dout,
   output logic drive
);
   logic [7:0] mem [0:524287];
   logic read_on;
   logic wr_n;
   // Drivers only open in the read combination
   assign read_on = !cs_n && !oe_n && we_n;
   assign wr_n = cs_n | we_n;
   // Byte lands on whichever of select or strobe rises first
   always @(posedge wr_n) begin
      mem[addr] = din;
   end
   // Slow on purpose: low Z late, and float takes the full 10 ns too
   always @(read_on) begin
      drive <= #10 read_on;
   end
   // Old byte turns to garbage after the hold, real byte at worst access
   always @(addr or read_on) begin
      dout <= #10 ~mem[addr];
      dout <= #55 mem[addr];
   end
endmodule

// ===== bench/sram_ctl_bench.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module sram_ctl_bench;
   logic REF_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic REQ_VALID = 1'b0;
   logic REQ_WRITE = 1'b0;
   logic [18:0] REQ_ADDR = 19'h0;
   logic [7:0] REQ_WDATA = 8'h0;
   logic RETAIN = 1'b0;
   logic REQ_READY, RD_VALID, MEM_CS_N, MEM_WE_N, MEM_OE_N;
   logic [7:0] RD_DATA, DATA_PORT_O, m_dout, last = 8'h00;
   logic [18:0] MEM_ADDR;
   logic DATA_PORT_OE, m_drive;
   wire [7:0] bus;
   int bad_count = 0;
   int checks = 0;
   realtime t_csf = 0.0, t_wef = 0.0, t_dat = 0.0, t_ret = -1000.0;
   logic [18:0] addrs [4] = '{19'h00000, 19'h7FFFF, 19'h12345, 19'h00000};
   logic [7:0] datas [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};

   always #4 REF_CLK = ~REF_CLK;
   // Released bus shows the inverse of the byte last driven on it,
   // so an early sample of a floating port never passes as good data
   assign bus = DATA_PORT_OE ? DATA_PORT_O : (m_drive ? m_dout : ~last);
   always @(posedge REF_CLK) begin
      if (DATA_PORT_OE === 1'b1 || m_drive === 1'b1) begin
         last <= bus;
      end
   end

   sram_ctl DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
      .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
      .RETAIN(RETAIN), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID),
      .RD_DATA(RD_DATA), .MEM_ADDR(MEM_ADDR), .MEM_CS_N(MEM_CS_N),
      .MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N), .DATA_PORT_I(bus),
      .DATA_PORT_O(DATA_PORT_O), .DATA_PORT_OE(DATA_PORT_OE));
   sram_model mem_model (.addr(MEM_ADDR), .cs_n(MEM_CS_N), .we_n(MEM_WE_N),
      .oe_n(MEM_OE_N), .din(bus), .dout(m_dout), .drive(m_drive));

   task automatic verify(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic final_report;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Pin timing seen from the wire, in ns
   always @(negedge MEM_CS_N) begin
      t_csf = $realtime;
      verify(t_csf - t_ret >= 55.0, "access too soon after retention");
   end
   always @(negedge MEM_WE_N) t_wef = $realtime;
   always @(DATA_PORT_O or posedge DATA_PORT_OE) t_dat = $realtime;
   always @(posedge MEM_CS_N) if (RESETN)
      verify($realtime - t_csf >= 55.0, "cycle too short");
   always @(posedge MEM_WE_N) if (RESETN) begin
      verify($realtime - t_wef >= 35.0, "strobe too short");
      verify($realtime - t_csf >= 40.0, "select too late");
      verify($realtime - t_dat >= 25.0, "data setup short");
      verify(DATA_PORT_OE, "data gone at write end");
   end
   always @(MEM_ADDR) if (RESETN)
      verify(MEM_CS_N | MEM_WE_N, "address moved in a write");
   always @(MEM_OE_N or MEM_WE_N) if (RESETN && !MEM_OE_N)
      verify(MEM_WE_N, "strobe low in a read");
   always @(DATA_PORT_OE or m_drive) if (DATA_PORT_OE && m_drive)
      verify(1'b0, "both sides drive the data port");
   always @(negedge RETAIN) t_ret = $realtime;

   // One request; a read is judged against the expected byte
   task automatic op(input logic wr, input logic [18:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      while (REQ_READY !== 1'b1 && n < 200) begin
         @(negedge REF_CLK);
         n++;
      end
      verify(n < 200, "ready never came");
      @(negedge REF_CLK);
      REQ_VALID = 1'b1;
      REQ_WRITE = wr;
      REQ_ADDR = a;
      REQ_WDATA = d;
      @(negedge REF_CLK);
      REQ_VALID = 1'b0;
      if (!wr) begin
         n = 0;
         while (RD_VALID !== 1'b1 && n < 40) begin
            @(negedge REF_CLK);
            n++;
         end
         verify(n < 40, "read valid never came");
         verify(RD_DATA === d, "read data wrong");
         @(negedge REF_CLK);
         verify(RD_VALID === 1'b0, "read valid too long");
      end
   endtask

   // Edge addresses, then an overwrite, then read back
   task automatic t_rw;
      for (int i = 0; i < 4; i++)
         op(1'b1, addrs[i], datas[i]);
      for (int i = 1; i < 4; i++)
         op(1'b0, addrs[i], datas[i]);
   endtask

   // Retention parks the pins; recovery gap is watched above
   task automatic t_retain;
      @(negedge REF_CLK);
      RETAIN = 1'b1;
      repeat (8) @(negedge REF_CLK);
      verify(MEM_CS_N === 1'b1, "select low in retention");
      verify(REQ_READY === 1'b0, "ready in retention");
      RETAIN = 1'b0;
      op(1'b0, 19'h7FFFF, 8'hFF);
   endtask

   initial begin
      // Reset only takes hold at the first clock edge, so look after it
      #6;
      verify(MEM_CS_N === 1'b1 && DATA_PORT_OE === 1'b0, "reset pins");
      repeat (2) @(negedge REF_CLK);
      RESETN = 1'b1;
      t_rw();
      t_retain();
      final_report();
   end

   // Cut a hang well past the expected run of about one microsecond
   initial begin
      #40000;
      verify(1'b0, "watchdog expired");
      final_report();
   end
endmodule
